// ==== shared/agr_params.svh ====
// Register offsets, field positions and reset values of the analog gain and offset bank.
`ifndef AGR_PARAMS_SVH
`define AGR_PARAMS_SVH
`define AGR_ADDR_W 6
`define AGR_OFF_SH_MODE 6'h06
`define AGR_OFF_LOCK_STATUS 6'h07
`define AGR_OFF_PROBE_SEL 6'h09
`define AGR_OFF_CH1_COARSE_MSB 6'h10
`define AGR_OFF_CH1_COARSE_LOW 6'h11
`define AGR_OFF_CH1_FINE_MSB 6'h12
`define AGR_OFF_CH1_FINE_LOW 6'h13
`define AGR_OFF_CH1_GAIN 6'h15
`define AGR_OFF_CH2_COARSE_MSB 6'h18
`define AGR_OFF_CH2_COARSE_LOW 6'h19
`define AGR_OFF_IRQ_STATUS 6'h3C
`define AGR_OFF_IRQ_ENABLE 6'h3D
`define AGR_OFF_IRQ_CLEAR 6'h3E
`define AGR_SH_EN_BIT 7
`define AGR_REFBUF_HI 2
`define AGR_REFBUF_LO 1
`define AGR_PROBE_HI 4
`define AGR_PROBE_LO 3
`define AGR_RST_SH_MODE 8'h81
`define AGR_RST_PROBE 2'h0
`define AGR_RST_MSB 1'h0
`define AGR_RST_LOW 8'hFF
`define AGR_RST_GAIN 8'h61
`define AGR_IRQ_FALSE_LOCK 0
`define AGR_IRQ_LOCK_LOST 1
`define AGR_IRQ_N 2
`endif

// ==== shared/agr_pkg.sv ====
// Types of the analog gain and offset bank.
`default_nettype none
package agr_pkg;
    typedef enum logic [1:0] {
        AGR_REFBUF_30 = 2'h0,
        AGR_REFBUF_60 = 2'h1,
        AGR_REFBUF_100 = 2'h2
    } agr_refbuf_t;
    typedef enum logic [3:0] {
        AGR_PROBE_OFF = 4'h1,
        AGR_PROBE_EVEN = 4'h2,
        AGR_PROBE_ODD = 4'h4,
        AGR_PROBE_TAG = 4'h8
    } agr_probe_t;
    typedef struct packed {
        logic [8:0] ch1_coarse_offset;
        logic [8:0] ch1_fine_offset;
        logic [7:0] ch1_gain;
        logic [8:0] ch2_coarse_offset;
    } agr_analog_t;
    typedef struct packed {
        logic clamp_even;
        logic sample_even;
        logic clamp_odd;
        logic sample_odd;
        logic odd_tag;
        logic adc_clk;
    } agr_strobes_t;
endpackage
`default_nettype wire

// ==== core/agr_regs.sv ====
// Analog gain, offset and timing probe register bank.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "agr_params.svh"
module agr_regs #(
    parameter int DATA_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [`AGR_ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic false_lock_i,
    input wire agr_pkg::agr_strobes_t strobes_i,
    output logic sh_enable_o,
    output agr_pkg::agr_refbuf_t refbuf_power_o,
    output agr_pkg::agr_analog_t analog_o,
    output logic timing_probe_pin0_o,
    output logic timing_probe_pin1_o,
    output logic timing_probe_oe_o,
    output logic irq_o
);
    if (DATA_W != 8) begin : g_width_check
        $error("agr_regs supports only 8-bit data");
    end

    localparam logic [7:0] RST_SH_MODE = `AGR_RST_SH_MODE;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic sh_en_q;
    logic [1:0] refbuf_q;
    logic [1:0] probe_q;
    logic c1c_msb_q;
    logic [7:0] c1c_low_q;
    logic c1f_msb_q;
    logic [7:0] c1f_low_q;
    logic [7:0] c1g_q;
    logic c2c_msb_q;
    logic [7:0] c2c_low_q;
    logic lock_q;
    logic [`AGR_IRQ_N-1:0] irq_sts_q;
    logic [`AGR_IRQ_N-1:0] irq_en_q;
    logic [`AGR_IRQ_N-1:0] irq_ev;
    logic [`AGR_IRQ_N-1:0] irq_clr;
    logic [7:0] rdata_d;
    agr_pkg::agr_probe_t probe_st;

    function automatic logic hit(input logic [`AGR_ADDR_W-1:0] off);
        hit = wr_i && (addr_i == off);
    endfunction

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sh_en_q <= RST_SH_MODE[`AGR_SH_EN_BIT];
            refbuf_q <= RST_SH_MODE[`AGR_REFBUF_HI:`AGR_REFBUF_LO];
            probe_q <= `AGR_RST_PROBE;
        end else begin
            if (hit(`AGR_OFF_SH_MODE)) begin
                sh_en_q <= wdata_i[`AGR_SH_EN_BIT];
                refbuf_q <= wdata_i[`AGR_REFBUF_HI:`AGR_REFBUF_LO];
            end
            if (hit(`AGR_OFF_PROBE_SEL)) begin
                probe_q <= wdata_i[`AGR_PROBE_HI:`AGR_PROBE_LO];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            c1c_msb_q <= `AGR_RST_MSB;
            c1c_low_q <= `AGR_RST_LOW;
            c1f_msb_q <= `AGR_RST_MSB;
            c1f_low_q <= `AGR_RST_LOW;
            c1g_q <= `AGR_RST_GAIN;
            c2c_msb_q <= `AGR_RST_MSB;
            c2c_low_q <= `AGR_RST_LOW;
        end else begin
            if (hit(`AGR_OFF_CH1_COARSE_MSB)) begin
                c1c_msb_q <= wdata_i[0];
            end
            if (hit(`AGR_OFF_CH1_COARSE_LOW)) begin
                c1c_low_q <= wdata_i;
            end
            if (hit(`AGR_OFF_CH1_FINE_MSB)) begin
                c1f_msb_q <= wdata_i[0];
            end
            if (hit(`AGR_OFF_CH1_FINE_LOW)) begin
                c1f_low_q <= wdata_i;
            end
            if (hit(`AGR_OFF_CH1_GAIN)) begin
                c1g_q <= wdata_i;
            end
            if (hit(`AGR_OFF_CH2_COARSE_MSB)) begin
                c2c_msb_q <= wdata_i[0];
            end
            if (hit(`AGR_OFF_CH2_COARSE_LOW)) begin
                c2c_low_q <= wdata_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs to the analog path
    // ------------------------------------------------------------
    assign sh_enable_o = sh_en_q;
    assign analog_o.ch1_coarse_offset = {c1c_msb_q, c1c_low_q};
    assign analog_o.ch1_fine_offset = {c1f_msb_q, c1f_low_q};
    assign analog_o.ch1_gain = c1g_q;
    assign analog_o.ch2_coarse_offset = {c2c_msb_q, c2c_low_q};

    always_comb begin
        case (refbuf_q)
            2'h3: refbuf_power_o = agr_pkg::AGR_REFBUF_100;
            2'h2, 2'h1: refbuf_power_o = agr_pkg::AGR_REFBUF_60;
            default: refbuf_power_o = agr_pkg::AGR_REFBUF_30;
        endcase
    end

    // ------------------------------------------------------------
    // Timing probe routing
    // ------------------------------------------------------------
    always_comb begin
        case (probe_q)
            2'h1: probe_st = agr_pkg::AGR_PROBE_EVEN;
            2'h2: probe_st = agr_pkg::AGR_PROBE_ODD;
            2'h3: probe_st = agr_pkg::AGR_PROBE_TAG;
            default: probe_st = agr_pkg::AGR_PROBE_OFF;
        endcase
    end

    // Probe pins are registered so that they never glitch on a select change.
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            timing_probe_pin0_o <= 1'b0;
            timing_probe_pin1_o <= 1'b0;
            timing_probe_oe_o <= 1'b0;
        end else begin
            case (probe_st)
                agr_pkg::AGR_PROBE_EVEN: begin
                    timing_probe_pin0_o <= strobes_i.clamp_even;
                    timing_probe_pin1_o <= strobes_i.sample_even;
                    timing_probe_oe_o <= 1'b1;
                end
                agr_pkg::AGR_PROBE_ODD: begin
                    timing_probe_pin0_o <= strobes_i.clamp_odd;
                    timing_probe_pin1_o <= strobes_i.sample_odd;
                    timing_probe_oe_o <= 1'b1;
                end
                agr_pkg::AGR_PROBE_TAG: begin
                    timing_probe_pin0_o <= strobes_i.odd_tag;
                    timing_probe_pin1_o <= strobes_i.adc_clk;
                    timing_probe_oe_o <= 1'b1;
                end
                default: begin
                    timing_probe_pin0_o <= 1'b0;
                    timing_probe_pin1_o <= 1'b0;
                    timing_probe_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Lock status and interrupts
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= false_lock_i;
        end
    end

    assign irq_ev[`AGR_IRQ_FALSE_LOCK] = false_lock_i && !lock_q;
    assign irq_ev[`AGR_IRQ_LOCK_LOST] = !false_lock_i && lock_q;
    assign irq_clr = hit(`AGR_OFF_IRQ_CLEAR) ? wdata_i[`AGR_IRQ_N-1:0] : '0;

    // Set wins over a clear in the same cycle.
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            irq_sts_q <= '0;
        end else begin
            irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            irq_en_q <= '0;
        end else if (hit(`AGR_OFF_IRQ_ENABLE)) begin
            irq_en_q <= wdata_i[`AGR_IRQ_N-1:0];
        end
    end

    assign irq_o = |(irq_sts_q & irq_en_q);

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        case (addr_i)
            `AGR_OFF_SH_MODE: rdata_d = {sh_en_q, 4'h0, refbuf_q, 1'b0};
            `AGR_OFF_LOCK_STATUS: rdata_d = {7'h00, lock_q};
            `AGR_OFF_PROBE_SEL: rdata_d = {3'h0, probe_q, 3'h0};
            `AGR_OFF_CH1_COARSE_MSB: rdata_d = {7'h00, c1c_msb_q};
            `AGR_OFF_CH1_COARSE_LOW: rdata_d = c1c_low_q;
            `AGR_OFF_CH1_FINE_MSB: rdata_d = {7'h00, c1f_msb_q};
            `AGR_OFF_CH1_FINE_LOW: rdata_d = c1f_low_q;
            `AGR_OFF_CH1_GAIN: rdata_d = c1g_q;
            `AGR_OFF_CH2_COARSE_MSB: rdata_d = {7'h00, c2c_msb_q};
            `AGR_OFF_CH2_COARSE_LOW: rdata_d = c2c_low_q;
            `AGR_OFF_IRQ_STATUS: rdata_d = {6'h00, irq_sts_q};
            `AGR_OFF_IRQ_ENABLE: rdata_d = {6'h00, irq_en_q};
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rdata_d;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_gain_write;
        wr_i && addr_i == `AGR_OFF_CH1_GAIN;
    endsequence

    property p_sh_en;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_i && addr_i == `AGR_OFF_SH_MODE |=> sh_enable_o == $past(wdata_i[7]);
    endproperty
    a_sh_en: assert property (p_sh_en) else $error("sample hold enable wrong");

    property p_refbuf;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (refbuf_q == 2'h0) == (refbuf_power_o == agr_pkg::AGR_REFBUF_30);
    endproperty
    a_refbuf: assert property (p_refbuf) else $error("reference power wrong");

    property p_status;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        rd_i && addr_i == `AGR_OFF_LOCK_STATUS |=> rdata_o == {7'h00, $past(lock_q)};
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");

    property p_probe_even;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        probe_q == 2'h1 && $past(probe_q) == 2'h1 |=>
            timing_probe_pin0_o == $past(strobes_i.clamp_even) && timing_probe_oe_o;
    endproperty
    a_probe_even: assert property (p_probe_even) else $error("even probe wrong");

    property p_probe_off;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        probe_q == 2'h0 |=> !timing_probe_oe_o && !timing_probe_pin1_o;
    endproperty
    a_probe_off: assert property (p_probe_off) else $error("probe not off");

    property p_coarse;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_i && addr_i == `AGR_OFF_CH1_COARSE_MSB |=>
            analog_o.ch1_coarse_offset[8] == $past(wdata_i[0]);
    endproperty
    a_coarse: assert property (p_coarse) else $error("coarse msb wrong");

    property p_fine;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_i && addr_i == `AGR_OFF_CH1_FINE_LOW |=>
            analog_o.ch1_fine_offset[7:0] == $past(wdata_i);
    endproperty
    a_fine: assert property (p_fine) else $error("fine low wrong");

    property p_gain;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_gain_write ##1 (rd_i && addr_i == `AGR_OFF_CH1_GAIN) |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_gain: assert property (p_gain) else $error("gain readback wrong");

    property p_ch2;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        rd_i && addr_i == `AGR_OFF_CH2_COARSE_MSB |=> rdata_o[7:1] == 7'h00;
    endproperty
    a_ch2: assert property (p_ch2) else $error("unused bits not zero");

    property p_ch2_low;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_i && addr_i == `AGR_OFF_CH2_COARSE_LOW |=>
            analog_o.ch2_coarse_offset[7:0] == $past(wdata_i);
    endproperty
    a_ch2_low: assert property (p_ch2_low) else $error("ch2 low wrong");

    property p_unused;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        rd_i && addr_i == `AGR_OFF_SH_MODE |=> rdata_o[6:3] == 4'h0 && rdata_o[0] == 1'b0;
    endproperty
    a_unused: assert property (p_unused) else $error("reserved bits not zero");

    sequence s_lock_rise;
        $rose(false_lock_i);
    endsequence

    sequence s_lock_fall;
        $past(resetn_i) && $fell(false_lock_i);
    endsequence

    // A clear that meets a new event in the same cycle must not hide it.
    property p_irq_rise;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_lock_rise |=> irq_sts_q[`AGR_IRQ_FALSE_LOCK];
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("false lock event lost");

    property p_irq_fall;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_lock_fall |=> irq_sts_q[`AGR_IRQ_LOCK_LOST];
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("lock lost event lost");

    property p_irq_clear;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_i && addr_i == `AGR_OFF_IRQ_CLEAR && wdata_i[`AGR_IRQ_FALSE_LOCK] && !false_lock_i |=>
            !irq_sts_q[`AGR_IRQ_FALSE_LOCK];
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("status bit not cleared");

    property p_refbuf_wr;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_i && addr_i == `AGR_OFF_SH_MODE |=> refbuf_power_o == (
            ($past(wdata_i[2:1]) == 2'h3) ? agr_pkg::AGR_REFBUF_100 :
            ($past(wdata_i[2:1]) == 2'h0) ? agr_pkg::AGR_REFBUF_30 : agr_pkg::AGR_REFBUF_60);
    endproperty
    a_refbuf_wr: assert property (p_refbuf_wr) else $error("reference power after write wrong");

    property p_probe_tag;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        probe_q == 2'h3 |=>
            timing_probe_pin1_o == $past(strobes_i.adc_clk) && timing_probe_oe_o;
    endproperty
    a_probe_tag: assert property (p_probe_tag) else $error("tag probe wrong");
endmodule // agr_regs
`default_nettype wire

// ==== test/agr_regs_tb.sv ====
// Self-checking testbench of the analog gain, offset and timing probe register bank.
`timescale 1ns/1ps
`default_nettype none
`include "agr_params.svh"
module agr_regs_tb;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [`AGR_ADDR_W-1:0] addr_i = '0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic false_lock_i = 1'b0;
    agr_pkg::agr_strobes_t strobes_i = '0;
    logic [7:0] rdata_o;
    logic sh_enable_o;
    agr_pkg::agr_refbuf_t refbuf_power_o;
    agr_pkg::agr_analog_t analog_o;
    logic timing_probe_pin0_o;
    logic timing_probe_pin1_o;
    logic timing_probe_oe_o;
    logic irq_o;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [5:0] sel;
    logic [5:0] offs [7] = '{6'h10, 6'h11, 6'h12, 6'h13, 6'h15, 6'h18, 6'h19};
    logic [7:0] wv [7] = '{8'hFF, 8'hA5, 8'hFE, 8'h3C, 8'hC3, 8'hFF, 8'h96};
    logic [7:0] rv [7] = '{8'h01, 8'hA5, 8'h00, 8'h3C, 8'hC3, 8'h01, 8'h96};
    logic [5:0] bl_off [9] = '{6'h06, 6'h09, 6'h10, 6'h11, 6'h12, 6'h13, 6'h15, 6'h18, 6'h19};
    logic [7:0] bl_val [9] = '{8'h81, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h61, 8'h00, 8'hFF};

    always #4 ref_clk_i = ~ref_clk_i;

    agr_regs u_agr_regs (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .false_lock_i(false_lock_i),
        .strobes_i(strobes_i),
        .sh_enable_o(sh_enable_o),
        .refbuf_power_o(refbuf_power_o),
        .analog_o(analog_o),
        .timing_probe_pin0_o(timing_probe_pin0_o),
        .timing_probe_pin1_o(timing_probe_pin1_o),
        .timing_probe_oe_o(timing_probe_oe_o),
        .irq_o(irq_o)
    );

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [34:0] exp, input logic [34:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask

    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        @(negedge ref_clk_i);
    endtask

    task automatic reg_rd(input logic [5:0] a, input logic [7:0] exp, input string name);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        chk(name, exp, rdata_o);
    endtask

    task automatic results;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Timeout
    // ----------------------------------------
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            results();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(negedge ref_clk_i);
        chk("sh_enable", 35'h1, sh_enable_o);
        chk("refbuf", agr_pkg::AGR_REFBUF_30, refbuf_power_o);
        chk("analog", {9'h0FF, 9'h0FF, 8'h61, 9'h0FF}, analog_o);
        chk("probe_oe", 35'h0, timing_probe_oe_o);
        reg_rd(`AGR_OFF_CH1_COARSE_MSB, 8'h00, "coarse_msb");
        reg_rd(`AGR_OFF_CH1_GAIN, 8'h61, "gain");
        reg_rd(`AGR_OFF_LOCK_STATUS, 8'h00, "status");
        // Software loads every writable register except the interrupt enable and clear with its baseline first.
        for (int i = 0; i < 9; i++) begin
            reg_wr(bl_off[i], bl_val[i]);
        end
        chk("sh_enable", 35'h1, sh_enable_o);
        chk("refbuf", agr_pkg::AGR_REFBUF_30, refbuf_power_o);
        chk("analog", {9'h0FF, 9'h0FF, 8'h61, 9'h0FF}, analog_o);
        chk("probe_oe", 35'h0, timing_probe_oe_o);
        reg_rd(`AGR_OFF_SH_MODE, 8'h80, "sh_mode");
        // Unused bits are written as ones and must read back as zero.
        for (int c = 0; c < 4; c++) begin
            reg_wr(`AGR_OFF_SH_MODE, {c[0], 4'hF, c[1:0], 1'b1});
            chk("sh_enable", c[0], sh_enable_o);
            chk("refbuf", (c == 3) ? agr_pkg::AGR_REFBUF_100 : (c == 0) ?
                agr_pkg::AGR_REFBUF_30 : agr_pkg::AGR_REFBUF_60, refbuf_power_o);
            reg_rd(`AGR_OFF_SH_MODE, {c[0], 4'h0, c[1:0], 1'b0}, "sh_mode");
        end
        for (int c = 0; c < 4; c++) begin
            reg_wr(`AGR_OFF_PROBE_SEL, {3'h0, c[1:0], 3'h0});
            for (int p = 0; p < 2; p++) begin
                sel = (p == 1) ? 6'h15 : 6'h2A;
                @(posedge ref_clk_i);
                strobes_i <= sel;
                settle(2);
                chk("probe_oe", (c != 0), timing_probe_oe_o);
                if (c != 0) begin
                    chk("probe_pin0", sel[7-2*c], timing_probe_pin0_o);
                    chk("probe_pin1", sel[6-2*c], timing_probe_pin1_o);
                end else begin
                    chk("probe_pin0", 35'h0, timing_probe_pin0_o);
                    chk("probe_pin1", 35'h0, timing_probe_pin1_o);
                end
            end
            reg_rd(`AGR_OFF_PROBE_SEL, {3'h0, c[1:0], 3'h0}, "probe_sel");
        end
        for (int i = 0; i < 7; i++) begin
            reg_wr(offs[i], wv[i]);
        end
        for (int i = 0; i < 7; i++) begin
            reg_rd(offs[i], rv[i], "offset_gain");
        end
        chk("analog", {9'h1A5, 9'h03C, 8'hC3, 9'h196}, analog_o);
        reg_wr(`AGR_OFF_CH1_COARSE_LOW, 8'h00);
        chk("analog", {9'h100, 9'h03C, 8'hC3, 9'h196}, analog_o);
        reg_wr(6'h20, 8'hFF);
        reg_rd(6'h20, 8'h00, "unmapped");
        @(negedge ref_clk_i);
        chk("rdata_idle", 35'h0, rdata_o);
        chk("analog", {9'h100, 9'h03C, 8'hC3, 9'h196}, analog_o);
        // False lock raises the status bit and the false lock event; its end raises the lock lost event.
        reg_wr(`AGR_OFF_IRQ_ENABLE, 8'h03);
        @(posedge ref_clk_i);
        false_lock_i <= 1'b1;
        settle(3);
        reg_rd(`AGR_OFF_LOCK_STATUS, 8'h01, "status");
        reg_wr(`AGR_OFF_LOCK_STATUS, 8'h00);
        reg_rd(`AGR_OFF_LOCK_STATUS, 8'h01, "status");
        chk("irq", 35'h1, irq_o);
        reg_rd(`AGR_OFF_IRQ_STATUS, 8'h01, "irq_status");
        @(posedge ref_clk_i);
        false_lock_i <= 1'b0;
        settle(3);
        reg_rd(`AGR_OFF_LOCK_STATUS, 8'h00, "status");
        reg_rd(`AGR_OFF_IRQ_STATUS, 8'h03, "irq_status");
        reg_wr(`AGR_OFF_IRQ_ENABLE, 8'h00);
        chk("irq_masked", 35'h0, irq_o);
        reg_wr(`AGR_OFF_IRQ_ENABLE, 8'h03);
        chk("irq", 35'h1, irq_o);
        reg_wr(`AGR_OFF_IRQ_CLEAR, 8'h03);
        chk("irq_cleared", 35'h0, irq_o);
        reg_rd(`AGR_OFF_IRQ_STATUS, 8'h00, "irq_status");
        reg_rd(`AGR_OFF_IRQ_ENABLE, 8'h03, "irq_enable");
        // An event in the same cycle as its clear leaves the status bit set.
        @(posedge ref_clk_i);
        addr_i <= `AGR_OFF_IRQ_CLEAR;
        wdata_i <= 8'h01;
        wr_i <= 1'b1;
        false_lock_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        @(negedge ref_clk_i);
        chk("irq_set_wins", 35'h1, irq_o);
        reg_rd(`AGR_OFF_IRQ_STATUS, 8'h01, "irq_set_wins");
        // A reset in mid-run brings every register back to its baseline.
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(negedge ref_clk_i);
        chk("sh_enable", 35'h1, sh_enable_o);
        chk("refbuf", agr_pkg::AGR_REFBUF_30, refbuf_power_o);
        chk("analog", {9'h0FF, 9'h0FF, 8'h61, 9'h0FF}, analog_o);
        chk("probe_oe", 35'h0, timing_probe_oe_o);
        chk("irq_reset", 35'h0, irq_o);
        reg_rd(`AGR_OFF_IRQ_ENABLE, 8'h00, "irq_enable");
        reg_rd(`AGR_OFF_LOCK_STATUS, 8'h01, "status");
        results();
    end
endmodule // agr_regs_tb
`default_nettype wire
